/* core/reset_seq_pkg.sv */
// Constants, field layouts and carrier types for the reset sequencer
package reset_seq_pkg;

   // Word indices; the byte address on the bus is four times the index
   localparam logic [5:0] IDX_CAUSE = 6'h00;
   localparam logic [5:0] IDX_CFG_ONE = 6'h1e;
   localparam logic [5:0] IDX_CFG_TWO = 6'h1f;

   // Values after reset
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [7:0] CAUSE_RESET = 8'h00;
   localparam logic [31:0] DAT_RESET = 32'h0000_0000;

   // Writable bits of system_config_one; the rest read as zero
   localparam logic [7:0] CFG_ONE_MASK = 8'h9f;

   // Counts in falling edges of the doubled oscillator clock
   localparam int PRESC_STAGES = 12;
   localparam logic [12:0] STOP_SHORT_CYC = 13'h0020;
   localparam logic [12:0] STOP_LONG_CYC = 13'h1000;
   localparam int POST_CYC = 64;
   localparam logic [5:0] POST_LAST = 6'(POST_CYC - 1);

   // Bus clock edges a released reset pin is ignored, covering synchroniser lag
   localparam int PIN_GUARD_CYC = 3;

   // Layout of system_config_one, bit 7 first
   typedef struct packed {
      logic wdg_period;
      logic [1:0] spare;
      logic lvd_disable;
      logic trip_level;
      logic short_stop;
      logic stop_enable;
      logic wdg_disable;
   } options_t;

   // Layout of reset_cause_register, bit 7 first
   typedef struct packed {
      logic por;
      logic pin;
      logic spare5;
      logic wdg;
      logic [1:0] spare3;
      logic lvd;
      logic spare0;
   } cause_t;

endpackage

/* core/reset_stop_recovery_sequencer.sv */
// Reset, stop recovery and watchdog sequencer with Wishbone registers
//
// What this block does
// [RULE_01] Each config register accepts one write per reset; later ones ignored.
// [RULE_02] Every config bit returns to zero on any reset.
// [RULE_03] Config registers sit at fixed addresses and read back any time.
// [RULE_04] Software should program config first thing after reset.
// [RULE_05] Config bits gate stop, watchdog, detector, trip level, timings.
// [RULE_06] Watchdog times out after 8176 or 262128 doubled clock cycles.
// [RULE_07] A stop instruction clears the prescaler.
// [RULE_08] Leaving stop samples the short recovery bit for the delay.
// [RULE_09] Stop recovery lasts 32 cycles when short, else 4096.
// [RULE_10] Crystal systems should keep the short recovery bit clear.
// [RULE_11] Low voltage event sets its cause flag and starts reset.
// [RULE_12] Low voltage reset holds the pin low for 4096 cycles.
// [RULE_13] After pin hold, 64 more cycles then the CPU leaves reset.
// [RULE_14] Pin is driven low for every internal reset source.
// [RULE_15] Twelve counting stages; the thirteenth resets them and ticks watchdog.
// [RULE_16] Prescaler advances on falling edges of the doubled clock.
// [RULE_17] Bus clocks stay off until power-on or stop delay expires.
// [RULE_18] Power-on initialises the logic, then enables the oscillator.
// [RULE_19] External pin reset alone leaves the prescaler untouched.
// [RULE_20] After any reset the prescaler runs freely.
// [RULE_21] Per-register write-once flag, cleared by reset, set by write.
`timescale 1ns/1ps
module reset_stop_recovery_sequencer #(
   parameter int unsigned WDG_SHORT_CYC = 8176,
   parameter int unsigned WDG_LONG_CYC = 262128
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // Classic Wishbone slave, byte address
   input wire logic [7:0] adr_i,
   input wire logic [31:0] dat_i,
   input wire logic [3:0] sel_i,
   input wire logic we_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Pins from outside the clock domain
   input wire logic doubled_osc_clock_i,
   input wire logic low_voltage_detector_i,
   input wire logic power_on_reset_signal_i,
   input wire logic reset_pin_n_i,
   // Core requests on the same clock
   input wire logic stop_exec_i,
   input wire logic wake_i,
   input wire logic watchdog_clear_i,
   // Reset pin, open drain
   output logic reset_pin_n_o,
   output logic reset_pin_oe_n_o,
   // System controls
   output logic cpu_reset_o,
   output logic internal_bus_clocks_o,
   output logic osc_enable_o,
   output logic watchdog_tick_o,
   output reset_seq_pkg::options_t options_o
);

   typedef enum logic [2:0] {
      ST_POR,
      ST_STAB,
      ST_HOLD,
      ST_EXT,
      ST_POST,
      ST_RUN,
      ST_STOP,
      ST_RECOVER
   } seq_state_t;

   localparam logic [17:0] WDG_SHORT_LAST = 18'(WDG_SHORT_CYC - 1);
   localparam logic [17:0] WDG_LONG_LAST = 18'(WDG_LONG_CYC - 1);

   logic [3:0] pins_s;
   logic osc_s;
   logic lvd_s;
   logic por_s;
   logic pin_s;
   logic osc_prev_q;
   logic lvd_prev_q;
   logic osc_fall;
   logic lvd_evt;
   logic wdg_to;
   logic pin_low;
   logic in_rst;
   logic rec_done;
   logic [reset_seq_pkg::PIN_GUARD_CYC-1:0] drive_hist_q;
   seq_state_t state_q;
   seq_state_t state_d;
   logic [reset_seq_pkg::PRESC_STAGES:0] presc_q;
   logic [5:0] post_cnt_q;
   logic [17:0] wdg_cnt_q;
   logic rec_short_q;
   reset_seq_pkg::options_t cfg_one_q;
   logic [7:0] cfg_two_q;
   logic done_one_q;
   logic done_two_q;
   reset_seq_pkg::cause_t cause_q;
   reset_seq_pkg::cause_t cause_set;
   logic drive_n_q;
   logic cpu_rst_q;
   logic bus_clk_q;
   logic osc_en_q;
   logic tick_q;
   logic ack_q;
   logic [31:0] dat_q;
   logic [5:0] idx;
   logic req;
   logic wr_one;
   logic wr_two;
   logic rd_cause;

   // All four pins are asynchronous; pin idles high, the rest low
   sync_two_flop #(
      .WIDTH(4),
      .RESET_VAL(4'h8)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i({reset_pin_n_i, power_on_reset_signal_i,
                low_voltage_detector_i, doubled_osc_clock_i}),
      .sync_o(pins_s)
   );

   assign {pin_s, por_s, lvd_s, osc_s} = pins_s;

   // Edge history of the synchronised oscillator and detector pins and of our own pin drive
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         osc_prev_q <= 1'b0;
         lvd_prev_q <= 1'b0;
         drive_hist_q <= '0;
      end else begin
         osc_prev_q <= osc_s;
         lvd_prev_q <= lvd_s;
         drive_hist_q <= {drive_hist_q[reset_seq_pkg::PIN_GUARD_CYC-2:0],
                          drive_n_q};
      end
   end

   // Prescaler steps on the falling edge of the doubled clock
   assign osc_fall = osc_prev_q & ~osc_s; // RULE_16

   // Detector counts only while enabled in config
   assign lvd_evt = lvd_s & ~lvd_prev_q & ~cfg_one_q.lvd_disable; // RULE_05

   // Our own drive echoes back late; ignore the pin until that settles
   assign pin_low = ~pin_s & (&drive_hist_q);

   assign in_rst = state_q inside {ST_POR, ST_STAB, ST_HOLD, ST_EXT,
                                   ST_POST};

   // Watchdog expiry, period picked by config
   assign wdg_to = osc_fall && state_q == ST_RUN &&
                   !cfg_one_q.wdg_disable && // RULE_05
                   wdg_cnt_q >= (cfg_one_q.wdg_period ? WDG_SHORT_LAST
                                                      : WDG_LONG_LAST); // RULE_06

   // Long delay ends on the thirteenth stage, short one at 32
   assign rec_done = rec_short_q ?
                     (presc_q == reset_seq_pkg::STOP_SHORT_CYC) :
                     (presc_q == reset_seq_pkg::STOP_LONG_CYC); // RULE_09

   // Sequencer next state; power-on beats everything, then low voltage
   always_comb begin
      state_d = state_q;
      if (por_s) begin
         state_d = ST_POR; // RULE_18
      end else if (lvd_evt && !(state_q inside {ST_POR, ST_STAB})) begin
         state_d = ST_HOLD; // RULE_11
      end else begin
         unique case (state_q)
            ST_POR: state_d = ST_STAB;
            ST_STAB, ST_HOLD: begin
               if (presc_q[reset_seq_pkg::PRESC_STAGES]) begin
                  state_d = ST_POST; // RULE_12
               end
            end
            ST_EXT: begin
               if (!pin_low) begin
                  state_d = ST_POST;
               end
            end
            ST_POST: begin
               if (osc_fall && post_cnt_q == reset_seq_pkg::POST_LAST) begin
                  state_d = ST_RUN; // RULE_13
               end
            end
            ST_RUN: begin
               if (wdg_to) begin
                  state_d = ST_HOLD;
               end else if (pin_low) begin
                  state_d = ST_EXT;
               end else if (stop_exec_i && cfg_one_q.stop_enable) begin
                  state_d = ST_STOP; // RULE_05
               end
            end
            ST_STOP: begin
               if (wake_i || pin_low) begin
                  state_d = ST_RECOVER;
               end
            end
            ST_RECOVER: begin
               if (rec_done) begin
                  state_d = ST_RUN;
               end
            end
         endcase
      end
   end

   // State register; a bus reset restarts from power-on
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= ST_POR;
      end else begin
         state_q <= state_d;
      end
   end

   // Prescaler; no external pin term, so pin resets keep its count
   always_ff @(posedge clk_i) begin
      if (rst_i || state_d == ST_POR) begin
         presc_q <= '0; // RULE_18 RULE_19
      end else if (state_d == ST_STOP) begin
         presc_q <= '0; // RULE_07
      end else if (state_d == ST_HOLD && state_q != ST_HOLD) begin
         presc_q <= '0; // RULE_12
      end else if (presc_q[reset_seq_pkg::PRESC_STAGES]) begin
         presc_q <= '0; // RULE_15
      end else if (osc_fall) begin
         presc_q <= presc_q + 13'h0001; // RULE_20
      end
   end

   // Release delay after the pin hold
   always_ff @(posedge clk_i) begin
      if (rst_i || state_q != ST_POST) begin
         post_cnt_q <= '0;
      end else if (osc_fall) begin
         post_cnt_q <= post_cnt_q + 6'h01; // RULE_13
      end
   end

   // Watchdog counter; counts doubled clock edges for an exact period
   always_ff @(posedge clk_i) begin
      if (rst_i || state_q != ST_RUN || watchdog_clear_i ||
          cfg_one_q.wdg_disable || wdg_to) begin
         wdg_cnt_q <= '0;
      end else if (osc_fall) begin
         wdg_cnt_q <= wdg_cnt_q + 18'h00001; // RULE_06
      end
   end

   // Recovery length frozen at the moment stop is left
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rec_short_q <= 1'b0;
      end else if (state_q == ST_STOP && state_d == ST_RECOVER) begin
         rec_short_q <= cfg_one_q.short_stop; // RULE_08
      end
   end

   // Registered controls, computed from the next state except the tick, which follows the thirteenth stage
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         drive_n_q <= 1'b0;
         cpu_rst_q <= 1'b1;
         bus_clk_q <= 1'b0;
         osc_en_q <= 1'b0;
         tick_q <= 1'b0;
      end else begin
         drive_n_q <= !(state_d inside {ST_POR, ST_STAB, ST_HOLD}); // RULE_14
         cpu_rst_q <= state_d inside {ST_POR, ST_STAB, ST_HOLD, ST_EXT,
                                      ST_POST}; // RULE_13
         bus_clk_q <= !(state_d inside {ST_POR, ST_STAB, ST_STOP,
                                        ST_RECOVER}); // RULE_17
         osc_en_q <= !(state_d inside {ST_POR, ST_STOP}); // RULE_18
         tick_q <= presc_q[reset_seq_pkg::PRESC_STAGES]; // RULE_15
      end
   end

   assign reset_pin_n_o = drive_n_q;
   assign reset_pin_oe_n_o = drive_n_q;
   assign cpu_reset_o = cpu_rst_q;
   assign internal_bus_clocks_o = bus_clk_q;
   assign osc_enable_o = osc_en_q;
   assign watchdog_tick_o = tick_q;
   assign options_o = cfg_one_q; // RULE_05

   // Bus decode; one ack per request, unmapped words read zero
   assign idx = adr_i[7:2];
   assign req = cyc_i && stb_i && !ack_q;
   assign wr_one = req && we_i && sel_i[0] &&
                   idx == reset_seq_pkg::IDX_CFG_ONE;
   assign wr_two = req && we_i && sel_i[0] &&
                   idx == reset_seq_pkg::IDX_CFG_TWO;
   assign rd_cause = req && !we_i && idx == reset_seq_pkg::IDX_CAUSE;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req;
      end
   end

   // Read data captured alongside the ack
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_q <= reset_seq_pkg::DAT_RESET;
      end else if (req && !we_i) begin
         unique case (idx)
            reset_seq_pkg::IDX_CAUSE: dat_q <= {24'h000000, cause_q};
            reset_seq_pkg::IDX_CFG_ONE: dat_q <= {24'h000000, cfg_one_q}; // RULE_03
            reset_seq_pkg::IDX_CFG_TWO: dat_q <= {24'h000000, cfg_two_q}; // RULE_03
            default: dat_q <= reset_seq_pkg::DAT_RESET;
         endcase
      end
   end

   assign ack_o = ack_q;
   assign dat_o = dat_q;

   // Config one; CPU is held in reset, so no write can race the clear
   always_ff @(posedge clk_i) begin
      if (rst_i || in_rst) begin
         cfg_one_q <= reset_seq_pkg::options_t'(reset_seq_pkg::CFG_RESET); // RULE_02
         done_one_q <= 1'b0; // RULE_21
      end else if (wr_one && !done_one_q) begin
         cfg_one_q <= reset_seq_pkg::options_t'(dat_i[7:0] &
                      reset_seq_pkg::CFG_ONE_MASK); // RULE_01
         done_one_q <= 1'b1; // RULE_21
      end
   end

   // Config two; kept as plain storage with the same write-once lock
   always_ff @(posedge clk_i) begin
      if (rst_i || in_rst) begin
         cfg_two_q <= reset_seq_pkg::CFG_RESET; // RULE_02
         done_two_q <= 1'b0; // RULE_21
      end else if (wr_two && !done_two_q) begin
         cfg_two_q <= dat_i[7:0]; // RULE_01
         done_two_q <= 1'b1; // RULE_21
      end
   end

   // Cause events of this cycle
   always_comb begin
      cause_set = '0;
      cause_set.lvd = lvd_evt; // RULE_11
      cause_set.wdg = wdg_to;
      cause_set.pin = state_d == ST_EXT && state_q != ST_EXT;
   end

   // Cause register; reading clears it, but a same-cycle event survives
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cause_q <= reset_seq_pkg::cause_t'(reset_seq_pkg::CAUSE_RESET);
      end else if (state_q == ST_POR) begin
         cause_q <= '{por: 1'b1, default: 1'b0};
      end else if (rd_cause) begin
         cause_q <= cause_set;
      end else begin
         cause_q <= cause_q | cause_set; // RULE_11
      end
   end

   // Checks on the sequencer and registers
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_stop_left;
      state_q == ST_STOP ##1 state_q == ST_RECOVER;
   endsequence

   sequence s_post_end;
      state_q == ST_POST && post_cnt_q == reset_seq_pkg::POST_LAST &&
      osc_fall && !por_s && !lvd_evt;
   endsequence

   a_cfg_write_once: assert property ( // RULE_01
      (wr_one && done_one_q && !in_rst) |=> $stable(cfg_one_q))
      else $error("config one changed after its single write");

   a_cfg_reset_zero: assert property ( // RULE_02
      in_rst |=> (cfg_one_q == '0 && cfg_two_q == 8'h00 && !done_one_q))
      else $error("config not cleared during reset");

   a_cfg_read_back: assert property ( // RULE_03
      (req && !we_i && idx == reset_seq_pkg::IDX_CFG_ONE) |=>
      (ack_o && dat_o[7:0] == $past(cfg_one_q) && dat_o[31:8] == 24'h0))
      else $error("config one read returned wrong data");

   a_wdg_short: assert property ( // RULE_06
      (osc_fall && state_q == ST_RUN && !por_s && !lvd_evt &&
       cfg_one_q.wdg_period && !cfg_one_q.wdg_disable &&
       wdg_cnt_q == 18'(WDG_SHORT_CYC - 1)) |=>
      (state_q == ST_HOLD && cause_q.wdg))
      else $error("short watchdog period did not expire");

   a_stop_clear: assert property ( // RULE_07
      (state_q == ST_RUN && state_d == ST_STOP) |=>
      (presc_q == '0 && !internal_bus_clocks_o))
      else $error("stop did not clear prescaler");

   a_recov_sample: assert property ( // RULE_08
      s_stop_left |-> rec_short_q == $past(cfg_one_q.short_stop))
      else $error("recovery length not sampled on stop exit");

   a_recov_short: assert property ( // RULE_09
      (state_q == ST_RECOVER && state_d == ST_RUN && rec_short_q) |->
      (presc_q == 13'h0020) ##1 internal_bus_clocks_o)
      else $error("short recovery ended at the wrong count");

   a_lvd_flag: assert property ( // RULE_11
      (lvd_evt && !por_s && !(state_q inside {ST_POR, ST_STAB})) |=>
      (cause_q.lvd && state_q == ST_HOLD && !reset_pin_oe_n_o))
      else $error("low voltage event not flagged");

   a_hold_pin: assert property ( // RULE_12
      $rose(state_q == ST_HOLD) |-> (presc_q == '0 && !reset_pin_n_o))
      else $error("hold entered without clear and pin drive");

   a_post_len: assert property ( // RULE_13
      s_post_end |=> (!cpu_reset_o && reset_pin_oe_n_o))
      else $error("CPU not released after post delay");

   a_presc_wrap: assert property ( // RULE_15
      presc_q[12] |=> (presc_q == '0 && watchdog_tick_o))
      else $error("thirteenth stage did not reset prescaler");

endmodule

/* core/sync_two_flop.sv */
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module sync_two_flop #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_q;

   // First stage feeds only the second stage
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_q <= RESET_VAL;
         sync_o <= RESET_VAL;
      end else begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end

endmodule

/* dv/osc_pin_model.sv */
// Oscillator and reset pin model standing beside the sequencer
`timescale 1ns/1ps
module osc_pin_model (
   input wire logic clk_i,
   input wire logic oe_n_i,
   input wire logic ext_low_i,
   output logic osc_o,
   output logic pin_n_o
);
   logic [1:0] div_q = 2'h0;

   // Doubled clock at a quarter of the bus rate, slow enough to sync
   always_ff @(posedge clk_i) begin
      div_q <= div_q + 2'h1;
   end
   assign osc_o = div_q[1];

   // Pin has a pull-up; device or outside switch may pull it low
   assign pin_n_o = ~((~oe_n_i) | ext_low_i);
endmodule

/* dv/tb_reset_stop_recovery_sequencer.sv */
// Self-checking bench for the reset and stop recovery sequencer
`timescale 1ns/1ps
module tb_reset_stop_recovery_sequencer;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [3:0] sel = 4'h0;
   logic we = 1'b0, cyc = 1'b0, stb = 1'b0;
   logic lvd = 1'b0, por = 1'b0, stop = 1'b0, wake = 1'b0;
   logic wclr = 1'b0, ext_low = 1'b0;
   logic [31:0] rdat;
   logic ack, pin_n, oe_n, cpu_rst, bus_clk, osc_en, tick, osc;
   logic pin_drv_n;
   reset_seq_pkg::options_t opts;
   int errors = 0, comparisons = 0, falls = 0, ticks = 0;
   logic osc_q = 1'b0;
   int h, p, f;

   always #12.5 clk_i = ~clk_i;

   // Count doubled clock falls and watchdog ticks for timing checks
   always @(posedge clk_i) begin
      osc_q <= osc;
      if (osc_q === 1'b1 && osc === 1'b0) falls++;
      if (tick === 1'b1) ticks++;
   end

   reset_stop_recovery_sequencer #(
      .WDG_SHORT_CYC(40),
      .WDG_LONG_CYC(200)
   ) dut (
      .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(wdat),
      .sel_i(sel), .we_i(we), .cyc_i(cyc), .stb_i(stb),
      .dat_o(rdat), .ack_o(ack), .doubled_osc_clock_i(osc),
      .low_voltage_detector_i(lvd), .power_on_reset_signal_i(por),
      .reset_pin_n_i(pin_n), .stop_exec_i(stop), .wake_i(wake),
      .watchdog_clear_i(wclr), .reset_pin_n_o(pin_drv_n),
      .reset_pin_oe_n_o(oe_n), .cpu_reset_o(cpu_rst),
      .internal_bus_clocks_o(bus_clk), .osc_enable_o(osc_en),
      .watchdog_tick_o(tick), .options_o(opts)
   );

   osc_pin_model partner (
      .clk_i(clk_i), .oe_n_i(oe_n), .ext_low_i(ext_low),
      .osc_o(osc), .pin_n_o(pin_n)
   );

   task automatic report_and_stop();
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Counts may slip by the synchroniser lag of up to two falls
   task automatic near(input int got, input int exp);
      check(32'(got >= exp - 2 && got <= exp + 2), 32'h1);
   endtask

   task automatic hang();
      errors++;
      report_and_stop();
   endtask

   // Classic single cycle; held until ack is sampled high
   task automatic wb(input logic [7:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      adr <= a; we <= w; wdat <= d; sel <= 4'h1; cyc <= 1'b1; stb <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      q = rdat;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      if (n >= 50) hang();
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      wb(a, 1'b1, {24'h0, d}, q);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb(a, 1'b0, 32'h0, q);
      check(q, e);
   endtask

   // One-cycle strobe; bit 0 stop, bit 1 wake, bit 2 watchdog clear
   task automatic pulse(input logic [2:0] m);
      @(posedge clk_i);
      {wclr, wake, stop} <= m;
      @(posedge clk_i);
      {wclr, wake, stop} <= 3'h0;
   endtask

   // Falls until the device starts driving the pin
   task automatic wait_drive(output int fo);
      int n, f0;
      n = 0;
      f0 = falls;
      while (oe_n !== 1'b0 && n < 2000) begin
         @(posedge clk_i);
         n++;
      end
      fo = falls - f0;
      if (n >= 2000) hang();
   endtask

   // Falls of pin hold, then falls until the core leaves reset
   task automatic wait_release(output int ho, output int po);
      int n, f0;
      n = 0;
      f0 = falls;
      while (oe_n !== 1'b1 && n < 40000) begin
         @(posedge clk_i);
         n++;
      end
      ho = falls - f0;
      f0 = falls;
      while (cpu_rst !== 1'b0 && n < 40000) begin
         @(posedge clk_i);
         n++;
      end
      po = falls - f0;
      if (n >= 40000) hang();
   endtask

   task automatic t_boot();
      repeat (5) @(posedge clk_i);
      check(cpu_rst, 1'b1);
      check(oe_n, 1'b0);
      check(pin_drv_n, 1'b0);
      check(opts, 8'h00);
      rst_i <= 1'b0;
      wait_release(h, p);
      near(h, 4096);
      near(p, 64);
      check(osc_en, 1'b1);
      wr(8'h78, 8'h07);
      rd_chk(8'h00, 32'h80);
      rd_chk(8'h00, 32'h00);
   endtask

   task automatic t_config();
      wr(8'h78, 8'hff);
      rd_chk(8'h78, 32'h07);
      check(opts, 8'h07);
      rd_chk(8'h7c, 32'h00);
      wr(8'h7c, 8'ha5);
      wr(8'h7c, 8'h5a);
      rd_chk(8'h7c, 32'ha5);
      rd_chk(8'h40, 32'h00);
   endtask

   // Stop, wake, then count falls until the bus clocks return
   task automatic t_stop(input int exp);
      int n, f0;
      pulse(3'h1);
      repeat (8) @(posedge clk_i);
      check(bus_clk, 1'b0);
      pulse(3'h2);
      n = 0;
      f0 = falls;
      while (bus_clk !== 1'b1 && n < exp * 5) begin
         @(posedge clk_i);
         n++;
      end
      near(falls - f0, exp);
      if (n >= exp * 5) hang();
   endtask

   task automatic t_ext();
      ext_low <= 1'b1;
      repeat (20) @(posedge clk_i);
      check(cpu_rst, 1'b1);
      check(opts, 8'h00);
      ext_low <= 1'b0;
      wait_release(h, p);
      near(p, 64);
      rd_chk(8'h00, 32'h40);
      // Long recovery kept, short watchdog period chosen
      wr(8'h78, 8'h80);
      pulse(3'h1);
      repeat (8) @(posedge clk_i);
      check(bus_clk, 1'b1);
   endtask

   // Clear first so the period is measured from a known start
   task automatic t_wdog();
      pulse(3'h4);
      wait_drive(f);
      near(f, 40);
      check(cpu_rst, 1'b1);
      check(pin_drv_n, 1'b0);
      wait_release(h, p);
      near(h, 4096);
      rd_chk(8'h00, 32'h10);
      // Watchdog off, stop on, long recovery kept
      wr(8'h78, 8'h03);
   endtask

   task automatic t_lvd();
      @(posedge clk_i);
      lvd <= 1'b1;
      wait_drive(f);
      lvd <= 1'b0;
      rd_chk(8'h00, 32'h02);
      wait_release(h, p);
      near(h, 4096);
      near(p, 64);
      check(bus_clk, 1'b1);
   endtask

   task automatic t_por();
      @(posedge clk_i);
      por <= 1'b1;
      repeat (8) @(posedge clk_i);
      check(osc_en, 1'b0);
      por <= 1'b0;
      wait_release(h, p);
      check(osc_en, 1'b1);
      rd_chk(8'h00, 32'h80);
      check(32'(ticks > 0), 32'h1);
   endtask

   initial begin
      t_boot();
      t_config();
      t_stop(32);
      t_ext();
      t_wdog();
      t_stop(4096);
      t_lvd();
      t_por();
      report_and_stop();
   end
endmodule
